// ---- include/adc_out_pkg.sv ----
// Constants shared by the result shift-out and clock-select logic.
// Assumes one 40 MHz system clock; serial and f0 pins sampled synchronously.
package adc_out_pkg;
    localparam int WORD_W = 32;
    localparam int RESULT_W = 24;
    localparam int SUB_W = 5;
    localparam int RAW_W = RESULT_W + SUB_W;
    localparam int FIFO_W = RAW_W + 2;
    localparam int FIFO_DEPTH = 16;
    // Word field positions
    localparam int DONE_POS = 31;
    localparam int DUMMY_POS = 30;
    localparam int SIGN_POS = 29;
    localparam int RESULT_MSB = 28;
    localparam int RESULT_LSB = 5;
    localparam int SUB_MSB = 4;
    localparam int SHIFT_COUNT = 32;
    // Clock figures
    localparam int CLK_HZ = 40_000_000;
    localparam int EXT_MIN_HZ = 10_000;
    // Longest f0 edge spacing accepted as an external clock (rounded down)
    localparam int EXT_TIMEOUT_CYC = CLK_HZ / EXT_MIN_HZ;
    localparam int NOTCH_DIVIDE = 5120;
    localparam int TMR_W = 16;
    // Rejection modes, simultaneous 50/60 after reset
    typedef enum logic [1:0] {
        REJ_BOTH = 2'b00,
        REJ_50 = 2'b01,
        REJ_60 = 2'b10
    } reject_mode_t;
    localparam reject_mode_t REJ_RESET = REJ_BOTH;
    localparam logic [RAW_W-1:0] FULL_SCALE_CODE = 29'h0100_0000;
    localparam logic [RAW_W-1:0] ZERO_CODE = 29'h0000_0000;
    // Over range: MSB high, rest low; under range: MSB low, rest high
    localparam logic [RAW_W-1:0] CLAMP_HIGH = 29'h1000_0000;
    localparam logic [RAW_W-1:0] CLAMP_LOW = 29'h0FFF_FFFF;
    localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
endpackage : adc_out_pkg

// ---- include/result_if.sv ----
// Carries finished results from the FIFO to the shift-out logic.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface result_if;
    logic valid;
    logic ready;
    logic [adc_out_pkg::FIFO_W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : result_if
`default_nettype wire

// ---- hdl/result_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; ce freezes all state.
`timescale 1ns/1ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Write side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Read side
    result_if.src out
);
    import adc_out_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    wire push = in_valid && in_ready;
    wire pop = out.valid && out.ready;
    assign in_ready = (count_r != (AW+1)'(DEPTH));
    assign out.valid = (count_r != '0);
    assign out.data = mem[rd_ptr_r];
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else if (ce) begin
            if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : result_fifo
`default_nettype wire

// ---- hdl/conv_clock_select.sv ----
// Detects an external conversion clock on the f0 pin and picks the source.
// Assumes the pin is synchronous to clk; ext clock well below clk/2.
`timescale 1ns/1ps
`default_nettype none
module conv_clock_select (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Pin and outputs
    input wire logic conversion_clock_pin,
    output logic ext_active,
    output logic conv_tick
);
    import adc_out_pkg::*;
    logic pin_d_r;
    logic [TMR_W-1:0] idle_r;
    logic [TMR_W-1:0] osc_r;
    logic ext_r;
    logic tick_r;
    wire rise = conversion_clock_pin && !pin_d_r;
    wire timed_out = (idle_r >= TMR_W'(EXT_TIMEOUT_CYC));
    // Internal oscillator stand-in, runs only when no external clock
    wire osc_wrap = (osc_r == TMR_W'(EXT_TIMEOUT_CYC / 8));
    assign ext_active = ext_r;
    assign conv_tick = tick_r;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_d_r <= 1'b0;
            idle_r <= TMR_ZERO;
            osc_r <= TMR_ZERO;
            ext_r <= 1'b0;
            tick_r <= 1'b0;
        end else if (ce) begin
            pin_d_r <= conversion_clock_pin;
            if (rise) idle_r <= TMR_ZERO;
            else if (!timed_out) idle_r <= idle_r + 1'b1;
            // Two edges within the window mean an external clock
            if (rise && !timed_out) ext_r <= 1'b1;
            else if (timed_out) ext_r <= 1'b0;
            osc_r <= (ext_r || osc_wrap) ? TMR_ZERO : osc_r + 1'b1;
            tick_r <= ext_r ? (rise && !timed_out) : osc_wrap;
        end
    end
endmodule : conv_clock_select
`default_nettype wire

// ---- hdl/adc_result_shift_out.sv ----
// Digital side of the converter: clock select, result formatting, serial out.
// Assumes serial pins already synchronous to clk; analog core gives raw words.
`timescale 1ns/1ps
`default_nettype none
module adc_result_shift_out (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // Serial port
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    // Conversion clock pin
    input wire logic conversion_clock_pin,
    // Analog core result: valid/ready handshake, raw code, sign and range flags
    input wire logic core_valid,
    output logic core_ready,
    input wire logic [adc_out_pkg::RAW_W-1:0] core_code,
    input wire logic core_sign,
    input wire logic core_over,
    input wire logic core_under,
    // Modes and status
    input wire logic double_speed_select,
    output logic ext_clock_active,
    output logic converting,
    output logic conv_start,
    output adc_out_pkg::reject_mode_t reject_mode,
    output logic [12:0] notch_divide
);
    import adc_out_pkg::*;
    typedef enum logic [1:0] {
        ST_CONVERT = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OUTPUT = 2'b10
    } state_t;
    state_t state_r;
    state_t state_nxt;
    logic [WORD_W-1:0] shift_r;
    logic [5:0] bits_r;
    logic sck_d_r;
    logic cs_d_r;
    logic started_r;
    logic [1:0] cfg_r;
    logic [1:0] cfg_cnt_r;
    reject_mode_t rej_r;
    logic sdo_r;
    logic oe_r;
    logic start_r;
    logic ext_w;
    logic tick_w;
    logic tick_seen_r;
    logic converting_r;
    logic [12:0] notch_r;
    result_if res();
    // Clamp and format the core's code
    wire [RAW_W-1:0] clamped = core_over ? CLAMP_HIGH :
                               core_under ? CLAMP_LOW : core_code;
    wire word_sign = core_over ? 1'b1 : core_under ? 1'b0 : core_sign;
    // Zero-code sign is passed through; either value is acceptable
    wire fifo_sign = word_sign;
    wire [FIFO_W-1:0] fifo_in = {double_speed_select, fifo_sign, clamped};
    result_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .in_valid(core_valid),
        .in_ready(core_ready),
        .in_data(fifo_in),
        .out(res.src)
    );
    conv_clock_select u_clksel (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .conversion_clock_pin(conversion_clock_pin),
        .ext_active(ext_w),
        .conv_tick(tick_w)
    );
    wire res_speed = res.data[FIFO_W-1];
    wire res_sign = res.data[FIFO_W-2];
    wire [RAW_W-1:0] res_code = res.data[RAW_W-1:0];
    wire [WORD_W-1:0] new_word = (res_speed && !res_sign && res_code[RAW_W-1:0] == CLAMP_LOW)
                                 ? {WORD_W{1'b0}}
                                 : {1'b0, 1'b0, res_sign, res_code};
    // Pin edges
    wire cs_active = !cs_n;
    wire sck_rise = sck && !sck_d_r && cs_active;
    wire sck_fall = !sck && sck_d_r && cs_active;
    wire cs_rise = cs_n && !cs_d_r;
    wire load = (state_r == ST_CONVERT) && res.valid && tick_seen_r;
    wire done_shift = sck_fall && (bits_r == 6'(SHIFT_COUNT - 1));
    wire abort = (state_r == ST_OUTPUT) && cs_rise && started_r;
    assign res.ready = load;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_CONVERT: if (load) state_nxt = ST_SLEEP;
            ST_SLEEP: if (cs_active) state_nxt = ST_OUTPUT;
            ST_OUTPUT: begin
                if (done_shift || abort) state_nxt = ST_CONVERT;
                else if (cs_n) state_nxt = ST_SLEEP;
            end
            default: state_nxt = ST_CONVERT;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= ST_CONVERT;
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
            tick_seen_r <= 1'b0;
            start_r <= 1'b0;
            converting_r <= 1'b1;
            notch_r <= 13'(NOTCH_DIVIDE);
        end else if (ce) begin
            state_r <= state_nxt;
            converting_r <= (state_nxt == ST_CONVERT);
            sck_d_r <= sck;
            cs_d_r <= cs_n;
            start_r <= (state_r != ST_CONVERT) && (state_nxt == ST_CONVERT);
            // A word is only accepted after a conversion clock tick, so each
            // conversion gives one word even across a source change
            if (state_r != ST_CONVERT) tick_seen_r <= 1'b0;
            else if (tick_w) tick_seen_r <= 1'b1;
        end
    end
    // Shift register and bit counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_r <= {WORD_W{1'b0}};
            bits_r <= 6'h00;
            started_r <= 1'b0;
        end else if (ce) begin
            if (load) begin
                shift_r <= new_word;
                bits_r <= 6'h00;
                started_r <= 1'b0;
            end else if (state_r == ST_OUTPUT) begin
                if (sck_rise) started_r <= 1'b1;
                if (sck_fall && started_r) begin
                    shift_r <= {shift_r[WORD_W-2:0], 1'b1};
                    bits_r <= bits_r + 6'h01;
                end
                if (cs_n && !started_r) bits_r <= 6'h00;
            end
        end
    end
    // Serial data out; shift happens off the system clock, immune to f0
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sdo_r <= 1'b1;
            oe_r <= 1'b0;
        end else if (ce) begin
            oe_r <= cs_active && !(cs_rise);
            unique case (state_nxt)
                ST_CONVERT: sdo_r <= 1'b1;
                ST_SLEEP: sdo_r <= 1'b0;
                ST_OUTPUT: sdo_r <= (load ? new_word[DONE_POS] : shift_r[WORD_W-1]);
                default: sdo_r <= 1'b1;
            endcase
        end
    end
    // Configuration from serial input: two mode bits on first rising edges
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_r <= 2'b00;
            cfg_cnt_r <= 2'b00;
            rej_r <= REJ_RESET;
        end else if (ce) begin
            if (state_r == ST_OUTPUT && sck_rise && cfg_cnt_r != 2'b10) begin
                cfg_r <= {cfg_r[0], sdi};
                cfg_cnt_r <= cfg_cnt_r + 2'b01;
            end else if (state_r != ST_OUTPUT) begin
                cfg_cnt_r <= 2'b00;
            end
            if (done_shift) begin
                unique case (cfg_r)
                    2'b01: rej_r <= REJ_50;
                    2'b10: rej_r <= REJ_60;
                    default: rej_r <= REJ_BOTH;
                endcase
            end
        end
    end
    assign sdo_o = sdo_r;
    assign sdo_oe = oe_r;
    assign ext_clock_active = ext_w;
    assign converting = converting_r;
    assign conv_start = start_r;
    assign reject_mode = rej_r;
    assign notch_divide = notch_r;
endmodule : adc_result_shift_out
`default_nettype wire

// ---- verification/adc_result_monitor.sv ----
// Port checker for the result shift-out block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module adc_result_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins
    input wire logic cs_n,
    input wire logic conversion_clock_pin,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    // Status
    input wire logic converting,
    input wire logic conv_start,
    input wire logic ext_clock_active,
    input wire adc_out_pkg::reject_mode_t reject_mode,
    input wire logic [12:0] notch_divide
);
    import adc_out_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic pin_d_r;
    logic [12:0] gap_r;
    // Cycles since the last rise on the conversion clock pin
    always_ff @(posedge clk) begin
        pin_d_r <= conversion_clock_pin;
        if (!reset_n) gap_r <= 13'h1FFF;
        else if (conversion_clock_pin && !pin_d_r) gap_r <= 13'h0000;
        else if (gap_r != 13'h1FFF) gap_r <= gap_r + 13'h0001;
    end
    property p_idle_release; cs_n[*4] |-> !sdo_oe; endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data out driven while deselected");
    property p_sck_ignored; cs_n[*5] |-> !conv_start; endproperty
    a_sck_ignored: assert property (p_sck_ignored)
        else $error("conversion started while deselected");
    property p_drive_sel; (!cs_n)[*4] |-> sdo_oe; endproperty
    a_drive_sel: assert property (p_drive_sel)
        else $error("data out not driven while selected");
    property p_done_flag; (!cs_n && converting)[*4] |-> sdo_o; endproperty
    a_done_flag: assert property (p_done_flag)
        else $error("done flag low during conversion");
    property p_start_pulse; conv_start |=> !conv_start && converting; endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse not single or not converting");
    property p_notch; notch_divide == 13'h1400; endproperty
    a_notch: assert property (p_notch)
        else $error("notch divider wrong");
    property p_reject_reset; $rose(reset_n) |-> reject_mode == REJ_RESET; endproperty
    a_reject_reset: assert property (p_reject_reset)
        else $error("rejection mode not default after reset");
    property p_ext_lost; ext_clock_active |-> gap_r <= 13'h0FAA; endproperty
    a_ext_lost: assert property (p_ext_lost)
        else $error("external clock kept without pin edges");
endmodule : adc_result_monitor
bind adc_result_shift_out adc_result_monitor i_adc_result_monitor (.clk(clk),
    .reset_n(reset_n), .cs_n(cs_n), .conversion_clock_pin(conversion_clock_pin),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .converting(converting), .conv_start(conv_start),
    .ext_clock_active(ext_clock_active), .reject_mode(reject_mode),
    .notch_divide(notch_divide));
`default_nettype wire

// ---- verification/host_reader.sv ----
// Host model that reads result words over the serial port.
// Assumes the block's clock; lines change on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
    // Clock
    input wire logic clk,
    // Serial lines
    output logic cs_n,
    output logic sck,
    output logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    localparam int HALF = 4;
    logic last_r = 1'h0;
    // Two mode bits sent on the first two rising edges of a word
    logic [1:0] mode = 2'b00;
    wire logic data_in;
    // A released line reads as the inverse of the last level
    assign data_in = sdo_oe ? sdo_o : ~last_r;
    always_ff @(posedge clk) begin
        last_r <= data_in;
    end
    initial begin
        cs_n = 1'h1;
        sck = 1'h0;
        sdi = 1'h0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask : gap
    // Serial clock pulses while deselected
    task automatic stray(input int n);
        repeat (n) begin
            sck = 1'h1;
            gap(HALF);
            sck = 1'h0;
            gap(HALF);
        end
    endtask : stray
    // Reads nfall bits after the flag; raises select early for an abort
    task automatic read_word(input int nfall, output logic [31:0] w, output logic tail);
        int k;
        w = 32'h0000_0000;
        tail = 1'h0;
        cs_n = 1'h0;
        gap(HALF);
        w[31] = data_in;
        for (k = 1; k <= nfall; k++) begin
            sdi = (k <= 2) ? mode[2-k] : 1'h0;
            sck = 1'h1;
            gap(HALF);
            sck = 1'h0;
            gap(HALF);
            if (k < 32) w[31-k] = data_in;
            else tail = data_in;
        end
        sdi = 1'h0;
        cs_n = 1'h1;
        gap(HALF);
    endtask : read_word
endmodule : host_reader
`default_nettype wire

// ---- verification/adc_result_shift_out_clock_select_tb_top.sv ----
// Testbench for the result shift-out and clock-select block.
// Assumes the host model drives the serial port; bench drives the core side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_result_shift_out_clock_select_tb_top;
    import adc_out_pkg::*;
    logic clk = 1'h0;
    logic reset_n, ce, cs_n, sck, sdi, sdo_o, sdo_oe, pin, ext_on, ds;
    logic core_valid, core_ready, core_sign, core_over, core_under;
    logic ext_act, converting, conv_start;
    logic [RAW_W-1:0] core_code;
    reject_mode_t reject_mode;
    logic [12:0] notch;
    int fails = 0;
    int checks = 0;
    adc_result_shift_out i_adc_result_shift_out (.clk(clk), .reset_n(reset_n), .ce(ce),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .conversion_clock_pin(pin), .core_valid(core_valid), .core_ready(core_ready),
        .core_code(core_code), .core_sign(core_sign), .core_over(core_over),
        .core_under(core_under), .double_speed_select(ds), .ext_clock_active(ext_act),
        .converting(converting), .conv_start(conv_start), .reject_mode(reject_mode),
        .notch_divide(notch));
    host_reader i_host_reader (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe));
    initial forever #12.5 clk = ~clk;
    // External conversion clock of 20 kHz while enabled
    initial forever begin
        repeat (1000) @(negedge clk);
        pin = ext_on ? ~pin : 1'h0;
    end
    task automatic close_out();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (90000) @(posedge clk);
        fails++;
        close_out();
    end
    // Hands one raw result over and waits for the conversion to finish
    task automatic push(input logic [RAW_W-1:0] code, input logic sg, ov, un, d);
        int n;
        n = 0;
        core_code = code;
        core_sign = sg;
        core_over = ov;
        core_under = un;
        ds = d;
        core_valid = 1'h1;
        while (core_ready !== 1'h1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        core_valid = 1'h0;
        n = 0;
        while (converting !== 1'h0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        `CHK(converting, 1'h0)
    endtask : push
    task automatic take(input logic [31:0] exp);
        logic [31:0] w;
        logic tail;
        i_host_reader.stray(3);
        `CHK(sdo_oe, 1'h0)
        i_host_reader.read_word(32, w, tail);
        `CHK(w, exp)
        `CHK(tail, 1'h1)
        `CHK(converting, 1'h1)
    endtask : take
    // Rejection mode written over the serial input during a read
    task automatic t_cfg();
        i_host_reader.mode = 2'b01;
        push(29'h0000_1111, 1'h1, 1'h0, 1'h0, 1'h0);
        take(32'h2000_1111);
        `CHK(reject_mode, REJ_50)
        i_host_reader.mode = 2'b10;
        push(29'h0000_2222, 1'h1, 1'h0, 1'h0, 1'h0);
        take(32'h2000_2222);
        `CHK(reject_mode, REJ_60)
        i_host_reader.mode = 2'b00;
    endtask : t_cfg
    task automatic t_abort();
        logic [31:0] w;
        logic tail;
        push(29'h0055_AA55, 1'h1, 1'h0, 1'h0, 1'h0);
        i_host_reader.read_word(0, w, tail);
        `CHK(w[31], 1'h0)
        i_host_reader.read_word(5, w, tail);
        `CHK(w[31:26], 6'h08)
        `CHK(converting, 1'h1)
        push(29'h0133_0001, 1'h0, 1'h0, 1'h0, 1'h0);
        take(32'h0133_0001);
    endtask : t_abort
    task automatic t_ext();
        ext_on = 1'h1;
        i_host_reader.gap(6000);
        `CHK(ext_act, 1'h1)
        push(29'h1000_0001, 1'h1, 1'h0, 1'h0, 1'h0);
        take(32'h3000_0001);
        ext_on = 1'h0;
        i_host_reader.gap(5000);
        `CHK(ext_act, 1'h0)
        push(29'h000F_0F0F, 1'h0, 1'h0, 1'h0, 1'h0);
        take(32'h000F_0F0F);
    endtask : t_ext
    initial begin
        reset_n = 1'h0;
        ce = 1'h1;
        pin = 1'h0;
        ext_on = 1'h0;
        ds = 1'h0;
        core_valid = 1'h0;
        core_code = 29'h0000_0000;
        {core_sign, core_over, core_under} = 3'h0;
        repeat (2) @(negedge clk);
        reset_n = 1'h1;
        `CHK(reject_mode, REJ_RESET)
        `CHK(notch, 13'h1400)
        push(29'h0ABC_DE55, 1'h1, 1'h0, 1'h0, 1'h0);
        take(32'h2ABC_DE55);
        push(29'h1234_5678, 1'h0, 1'h0, 1'h0, 1'h0);
        take(32'h1234_5678);
        push(29'h0000_0000, 1'h1, 1'h1, 1'h0, 1'h0);
        take(32'h3000_0000);
        push(29'h0000_0000, 1'h0, 1'h0, 1'h1, 1'h0);
        take(32'h0FFF_FFFF);
        push(29'h0000_0000, 1'h0, 1'h0, 1'h1, 1'h1);
        take(32'h0000_0000);
        t_cfg();
        t_abort();
        t_ext();
        `CHK(reject_mode, REJ_RESET)
        close_out();
    end
endmodule : adc_result_shift_out_clock_select_tb_top
`default_nettype wire
